// ==== core/loop_sup_pkg.sv ====
// Register map, field layout, constants and bus carriers of the loop supervisor.
package loop_sup_pkg;
	localparam int ADDR_W = 12;
	localparam int IDX_W = ADDR_W - 2;
	localparam int DAC_W = 7;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_REVAL = 10'h015;
	localparam logic [IDX_W-1:0] IDX_EXIT = 10'h016;
	localparam logic [IDX_W-1:0] IDX_HOLD = 10'h029;
	localparam logic [IDX_W-1:0] IDX_CTRL = 10'h040;
	localparam logic [IDX_W-1:0] IDX_PRESC = 10'h041;
	localparam logic [IDX_W-1:0] IDX_STATE = 10'h082;
	localparam logic [IDX_W-1:0] IDX_STATUS = 10'h083;

	// Field positions.
	localparam int F_CRIT = 0;
	localparam int F_ACT = 2;
	localparam int F_MANREF = 0;
	localparam int F_DACEN = 2;
	localparam int F_AUTO = 0;
	localparam int F_FORCE = 1;
	localparam int F_REFEN = 4;
	localparam int F_SLOW = 4;
	localparam int F_LOCK = 5;
	localparam int F_SHORT = 6;

	// Reset values.
	localparam logic [7:0] CTRL_RST = 8'hF1;
	localparam logic [7:0] PRESC_RST = 8'h01;
	localparam logic [2:0] REVAL_RST = 3'h0;
	localparam logic [3:0] EXIT_RST = 4'h0;
	localparam logic [2:0] HOLD_RST = 3'h0;

	// Exit criteria and actions.
	localparam logic [1:0] CRIT_LOS = 2'h0;
	localparam logic [1:0] CRIT_PHASE = 2'h1;
	localparam logic [1:0] ACT_RESET = 2'h0;
	localparam logic [1:0] ACT_SLIP = 2'h1;
	localparam logic [1:0] ACT_DAC = 2'h3;

	// Edge monitor and revalidation figures.
	localparam logic [1:0] EDGE_LIMIT = 2'h3;
	localparam logic [1:0] REVAL_LAST = 2'h2;
	localparam logic [2:0] REVAL_SEL_MAX = 3'h7;
	localparam logic [6:0] REVAL_MAX = 7'h40;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_INIT, ST_PRELOAD, ST_ACQUIRE, ST_LOCKED,
		ST_HOLD, ST_EXIT_SLIP, ST_EXIT_RESET, ST_EXIT_RAMP
	} loop_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axil_rsp_t;
endpackage : loop_sup_pkg

// ==== core/loop_supervisor.sv ====
// Reference monitor, holdover and exit control of the input jitter-cleaning loop.
`timescale 1ns/1ns
`default_nettype none

module loop_supervisor #(
	parameter int NREF       = 4,
	parameter int PRESC_W    = 8,
	parameter int LOCK_TICKS = 1024,
	parameter int FILT_SHIFT = 4,
	parameter int IMP_STEPS  = 16
) (
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	input  wire logic                      ce,
	input  wire loop_sup_pkg::axil_req_t   axi_req,
	output var  loop_sup_pkg::axil_rsp_t   axi_rsp,
	input  wire logic [NREF-1:0]           ref_clk_in,
	input  wire logic                      osc_clk_in,
	input  wire logic                      phase_err_wide,
	input  wire logic                      phase_slip,
	input  wire logic [6:0]                tuning_sample,
	output logic                           charge_pump_tristate,
	output logic                           dac_force,
	output logic [6:0]                     dac_code,
	output logic [$clog2(IMP_STEPS)-1:0]   dac_impedance,
	output logic                           div_restart,
	output logic                           osc_slow_warn,
	output logic                           lock_detect,
	output logic [NREF-1:0]                signal_lost_flag,
	output logic [2:0]                     loop_state_code
);
	import loop_sup_pkg::*;

	localparam int NCH = NREF + 1;
	localparam int NPIN = NCH + 2;
	localparam int LK_W = $clog2(LOCK_TICKS + 1);
	localparam int IMP_W = $clog2(IMP_STEPS);
	localparam int ACC_W = DAC_W + FILT_SHIFT;

	logic [NPIN-1:0]    pin_raw, sync1_q, sync2_q, prev_q;
	logic [NCH-1:0]     div_edge;
	logic               cr_tick, err_s, slip_rise;
	logic [PRESC_W-1:0] presc_q [NCH];
	logic [7:0]         ctrl_q;
	logic [2:0]         reval_sel_q;
	logic [3:0]         exit_q;
	logic [2:0]         hold_q;
	logic [NREF-1:0]    lost_vec, slow_vec, ref_en;
	logic               auto_mode, force_hold, dac_en;
	logic [1:0]         crit, act, man_ref;
	loop_state_t        state_q;

	assign auto_mode = ctrl_q[F_AUTO];
	assign force_hold = ctrl_q[F_FORCE];
	assign ref_en = ctrl_q[F_REFEN +: NREF];
	assign crit = exit_q[F_CRIT +: 2];
	assign act = exit_q[F_ACT +: 2];
	assign man_ref = hold_q[F_MANREF +: 2];
	assign dac_en = hold_q[F_DACEN];

	// Every pin passes two flip-flops; a third stage gives the edge reference.
	assign pin_raw = {phase_slip, phase_err_wide, osc_clk_in, ref_clk_in};
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else if (ce) begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	assign err_s = sync2_q[NCH];
	assign slip_rise = sync2_q[NCH+1] & ~prev_q[NCH+1];

	// One prescaler per input; wrapping on reaching the limit recovers from any bad count.
	for (genvar c = 0; c < NCH; c++) begin : g_presc
		logic [PRESC_W-1:0] cnt_q;
		logic [PRESC_W-1:0] lim;
		logic               rise;
		assign rise = sync2_q[c] & ~prev_q[c];
		assign lim = (presc_q[c] == '0) ? '0 : presc_q[c] - 1'b1;
		assign div_edge[c] = rise & (cnt_q >= lim);
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				cnt_q <= '0;
			end else if (ce && rise) begin
				cnt_q <= (cnt_q >= lim) ? '0 : cnt_q + 1'b1;
			end
		end
	end
	assign cr_tick = div_edge[NREF];

	// Free-running revalidation timer at the common rate.
	logic [6:0] vt_cnt_q, vt_period;
	logic       vt_expire;
	always_comb begin
		if (reval_sel_q == '0) begin
			vt_period = '0;
		end else if (reval_sel_q == REVAL_SEL_MAX) begin
			vt_period = REVAL_MAX;
		end else begin
			vt_period = 7'h01 << reval_sel_q;
		end
	end
	assign vt_expire = cr_tick & (vt_period != '0) & (vt_cnt_q >= vt_period - 1'b1);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			vt_cnt_q <= '0;
		end else if (ce && cr_tick) begin
			vt_cnt_q <= vt_expire ? '0 : vt_cnt_q + 1'b1;
		end
	end

	// Per-reference loss monitor, revalidation and slow-oscillator check.
	for (genvar i = 0; i < NREF; i++) begin : g_mon
		logic [1:0] osc_cnt_q, ref_cnt_q, val_cnt_q;
		logic       lost_q, slow_q, lose_ev;
		assign lose_ev = cr_tick & ~div_edge[i] & (osc_cnt_q == EDGE_LIMIT - 1'b1);
		assign lost_vec[i] = lost_q;
		assign slow_vec[i] = slow_q;
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				osc_cnt_q <= '0;
			end else if (ce) begin
				if (div_edge[i]) begin
					osc_cnt_q <= '0;
				end else if (cr_tick && osc_cnt_q != EDGE_LIMIT) begin
					osc_cnt_q <= osc_cnt_q + 1'b1;
				end
			end
		end
		// A reference starts flagged and must earn its way in.
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				lost_q <= 1'b1;
				val_cnt_q <= '0;
			end else if (ce) begin
				if (lose_ev) begin
					lost_q <= 1'b1;
					val_cnt_q <= '0;
				end else if (lost_q && osc_cnt_q == EDGE_LIMIT) begin
					val_cnt_q <= '0;
				end else if (lost_q && vt_period == '0 && div_edge[i]) begin
					lost_q <= 1'b0;
				end else if (lost_q && vt_expire) begin
					if (val_cnt_q == REVAL_LAST) begin
						lost_q <= 1'b0;
						val_cnt_q <= '0;
					end else begin
						val_cnt_q <= val_cnt_q + 1'b1;
					end
				end
			end
		end
		// Three reference edges inside one oscillator period mark the oscillator slow.
		always_ff @(posedge clk_sys) begin
			if (sys_rst) begin
				ref_cnt_q <= '0;
				slow_q <= 1'b0;
			end else if (ce) begin
				if (cr_tick) begin
					slow_q <= (ref_cnt_q == EDGE_LIMIT);
					ref_cnt_q <= {1'b0, div_edge[i]};
				end else if (div_edge[i] && ref_cnt_q != EDGE_LIMIT) begin
					ref_cnt_q <= ref_cnt_q + 1'b1;
				end
			end
		end
	end

	// Warning only; nothing downstream acts on it.
	logic warn_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			warn_q <= 1'b0;
		end else if (ce) begin
			warn_q <= |(slow_vec & ref_en & ~lost_vec);
		end
	end

	// Lock detect counts common-rate cycles free of wide phase error.
	logic [LK_W-1:0] lock_cnt_q;
	logic            lock_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lock_cnt_q <= '0;
			lock_q <= 1'b0;
		end else if (ce) begin
			if (err_s) begin
				lock_cnt_q <= '0;
				lock_q <= 1'b0;
			end else if (cr_tick && !lock_q) begin
				if (lock_cnt_q == LK_W'(LOCK_TICKS - 1)) begin
					lock_q <= 1'b1;
				end
				lock_cnt_q <= lock_cnt_q + 1'b1;
			end
		end
	end

	// Fast tristate on clk_sys, ahead of the common-rate FSM.
	logic short_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			short_q <= 1'b0;
		end else if (ce) begin
			if (state_q == ST_LOCKED && err_s) begin
				short_q <= 1'b1;
			end else if (state_q != ST_LOCKED || lock_q) begin
				short_q <= 1'b0;
			end
		end
	end

	// Candidate reference: lowest-numbered enabled input without loss.
	logic [1:0] best;
	logic       any_ok;
	always_comb begin
		best = '0;
		any_ok = 1'b0;
		for (int k = NREF - 1; k >= 0; k--) begin
			if (ref_en[k] && !lost_vec[k]) begin
				best = 2'(k);
				any_ok = 1'b1;
			end
		end
	end

	// Slip seen while waiting for zero phase error; a new slip wins over the clear.
	logic slip_seen_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			slip_seen_q <= 1'b0;
		end else if (ce) begin
			if (slip_rise) begin
				slip_seen_q <= 1'b1;
			end else if (state_q != ST_EXIT_SLIP) begin
				slip_seen_q <= 1'b0;
			end
		end
	end

	// Loop state machine, stepped once per common-rate cycle.
	logic [1:0]       active_q;
	logic [IMP_W-1:0] imp_q;
	logic             lost_act, exit_ok;
	assign lost_act = lost_vec[active_q];
	assign exit_ok = auto_mode ? any_ok : ~force_hold;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= ST_INIT;
			active_q <= '0;
			imp_q <= '0;
		end else if (ce && cr_tick) begin
			case (state_q)
				ST_INIT: begin
					state_q <= ST_PRELOAD;
				end
				ST_PRELOAD: begin
					if (!auto_mode) begin
						active_q <= man_ref;
						state_q <= ST_ACQUIRE;
					end else if (any_ok) begin
						active_q <= best;
						state_q <= ST_ACQUIRE;
					end
				end
				ST_ACQUIRE: begin
					if (auto_mode && lost_act) begin
						state_q <= ST_PRELOAD;
					end else if (!auto_mode && force_hold) begin
						state_q <= ST_HOLD;
					end else if (lock_q) begin
						state_q <= ST_LOCKED;
					end
				end
				ST_LOCKED: begin
					if (auto_mode ? (lost_act || !lock_q) : force_hold) begin
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					imp_q <= '0;
					if (exit_ok) begin
						active_q <= auto_mode ? best : man_ref;
						if (crit == CRIT_PHASE && act == ACT_SLIP) begin
							state_q <= ST_EXIT_SLIP;
						end else begin
							state_q <= ST_EXIT_RESET;
						end
					end
				end
				ST_EXIT_SLIP: begin
					if (!exit_ok || (auto_mode && lost_act)) begin
						state_q <= ST_HOLD;
					end else if (slip_seen_q && !err_s) begin
						state_q <= ST_ACQUIRE;
					end
				end
				ST_EXIT_RESET: begin
					if (act == ACT_DAC && dac_en) begin
						state_q <= ST_EXIT_RAMP;
					end else begin
						state_q <= ST_ACQUIRE;
					end
				end
				ST_EXIT_RAMP: begin
					if (imp_q == IMP_W'(IMP_STEPS - 1)) begin
						state_q <= ST_ACQUIRE;
					end else begin
						imp_q <= imp_q + 1'b1;
					end
				end
				default: begin
					state_q <= ST_INIT;
				end
			endcase
		end
	end

	// Divider restart pulse, one clk_sys cycle, as the reset exit step runs.
	logic restart_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			restart_q <= 1'b0;
		end else if (ce) begin
			restart_q <= cr_tick & (state_q == ST_EXIT_RESET);
		end
	end

	// Tuning average, updated only while the loop is locked.
	logic [ACC_W-1:0]        avg_q;
	logic signed [ACC_W:0]   diff;
	assign diff = $signed({1'b0, tuning_sample, {FILT_SHIFT{1'b0}}}) - $signed({1'b0, avg_q});
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			avg_q <= {1'b1, {(ACC_W - 1){1'b0}}};
		end else if (ce && cr_tick && lock_q && state_q == ST_LOCKED) begin
			avg_q <= avg_q + ACC_W'(diff >>> FILT_SHIFT);
		end
	end

	// Pump and converter controls decoded from the state.
	logic fsm_tri, fsm_dac;
	always_comb begin
		fsm_tri = (state_q == ST_INIT) || (state_q == ST_PRELOAD) || (state_q == ST_HOLD)
			|| (state_q == ST_EXIT_SLIP) || (state_q == ST_EXIT_RESET);
		fsm_dac = (dac_en && ((state_q == ST_HOLD) || (state_q == ST_EXIT_SLIP)
			|| (state_q == ST_EXIT_RESET))) || (state_q == ST_EXIT_RAMP);
	end
	assign charge_pump_tristate = fsm_tri | short_q;
	assign dac_force = fsm_dac;
	assign dac_code = avg_q[ACC_W-1 -: DAC_W];
	assign dac_impedance = imp_q;
	assign div_restart = restart_q;
	assign osc_slow_warn = warn_q;
	assign lock_detect = lock_q;
	assign signal_lost_flag = lost_vec;
	assign loop_state_code = state_q;

	// AXI4-Lite slave: address and data taken in either order, one of each at a time.
	logic             aw_have_q, w_have_q, bvalid_q, rvalid_q, do_write;
	logic [IDX_W-1:0] aw_idx_q;
	logic [7:0]       wbyte_q;
	logic             wstb_q;
	logic [1:0]       bresp_q, rresp_q;
	logic [31:0]      rdata_q, rd_data;
	logic             rd_ok;
	logic [IDX_W-1:0] rd_idx;

	function automatic logic mapped(input logic [IDX_W-1:0] idx);
		mapped = (idx == IDX_REVAL) || (idx == IDX_EXIT) || (idx == IDX_HOLD)
			|| (idx == IDX_CTRL) || (idx == IDX_STATE) || (idx == IDX_STATUS)
			|| (idx >= IDX_PRESC && idx < IDX_PRESC + IDX_W'(NCH));
	endfunction : mapped

	assign do_write = ce & aw_have_q & w_have_q & ~bvalid_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			aw_idx_q <= '0;
			wbyte_q <= '0;
			wstb_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (axi_req.awvalid && axi_rsp.awready) begin
				aw_have_q <= 1'b1;
				aw_idx_q <= axi_req.awaddr[ADDR_W-1:2];
			end
			if (axi_req.wvalid && axi_rsp.wready) begin
				w_have_q <= 1'b1;
				wbyte_q <= axi_req.wdata[7:0];
				wstb_q <= axi_req.wstrb[0];
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && axi_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Writable configuration; status registers ignore writes.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RST;
			reval_sel_q <= REVAL_RST;
			exit_q <= EXIT_RST;
			hold_q <= HOLD_RST;
			for (int c = 0; c < NCH; c++) begin
				presc_q[c] <= PRESC_W'(PRESC_RST);
			end
		end else if (do_write && wstb_q) begin
			if (aw_idx_q == IDX_CTRL) ctrl_q <= wbyte_q;
			if (aw_idx_q == IDX_REVAL) reval_sel_q <= wbyte_q[2:0];
			if (aw_idx_q == IDX_EXIT) exit_q <= wbyte_q[3:0];
			if (aw_idx_q == IDX_HOLD) hold_q <= wbyte_q[2:0];
			for (int c = 0; c < NCH; c++) begin
				if (aw_idx_q == IDX_PRESC + IDX_W'(c)) presc_q[c] <= wbyte_q[PRESC_W-1:0];
			end
		end
	end

	// Read decode.
	assign rd_idx = axi_req.araddr[ADDR_W-1:2];
	always_comb begin
		rd_data = '0;
		rd_ok = mapped(rd_idx);
		if (rd_idx == IDX_CTRL) rd_data[7:0] = ctrl_q;
		if (rd_idx == IDX_REVAL) rd_data[2:0] = reval_sel_q;
		if (rd_idx == IDX_EXIT) rd_data[3:0] = exit_q;
		if (rd_idx == IDX_HOLD) rd_data[2:0] = hold_q;
		if (rd_idx == IDX_STATE) rd_data[2:0] = state_q;
		if (rd_idx == IDX_STATUS) begin
			rd_data[NREF-1:0] = lost_vec;
			rd_data[F_SLOW] = warn_q;
			rd_data[F_LOCK] = lock_q;
			rd_data[F_SHORT] = short_q;
		end
		for (int c = 0; c < NCH; c++) begin
			if (rd_idx == IDX_PRESC + IDX_W'(c)) rd_data[PRESC_W-1:0] = presc_q[c];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (axi_req.arvalid && axi_rsp.arready) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_data;
				rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && axi_req.rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Ready terms are held low while the clock enable is low so no handshake is lost.
	always_comb begin
		axi_rsp.awready = ce & ~aw_have_q & ~bvalid_q;
		axi_rsp.wready = ce & ~w_have_q & ~bvalid_q;
		axi_rsp.bvalid = bvalid_q;
		axi_rsp.bresp = bresp_q;
		axi_rsp.arready = ce & ~rvalid_q;
		axi_rsp.rvalid = rvalid_q;
		axi_rsp.rdata = rdata_q;
		axi_rsp.rresp = rresp_q;
	end
endmodule : loop_supervisor

`default_nettype wire

// ==== sim/loop_sup_asserts.sv ====
// Concurrent checks on the ports of the loop supervisor.
`timescale 1ns/1ns
`default_nettype none

module loop_sup_asserts
	import loop_sup_pkg::*;
(
	input wire logic      clk_sys,
	input wire logic      sys_rst,
	input wire logic      ce,
	input wire axil_req_t axi_req,
	input wire axil_rsp_t axi_rsp,
	input wire logic      phase_err_wide,
	input wire logic      charge_pump_tristate,
	input wire logic      dac_force,
	input wire logic      div_restart,
	input wire logic      lock_detect,
	input wire logic [2:0] loop_state_code
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// Holdover and the slip wait keep the pump off the loop filter.
	chk_hold_tristate: assert property (loop_state_code == ST_HOLD |-> charge_pump_tristate)
		else $error("pump driven while in holdover");
	chk_slip_tristate: assert property (loop_state_code == ST_EXIT_SLIP |-> charge_pump_tristate)
		else $error("pump driven while waiting for slip");
	// A wide phase error while locked shuts the pump within the sync delay.
	chk_fast_tristate: assert property ((ce && phase_err_wide && loop_state_code == ST_LOCKED)[*4]
		|=> charge_pump_tristate)
		else $error("pump not tristated on wide phase error");
	chk_err_unlock: assert property ((ce && phase_err_wide)[*4] |=> !lock_detect)
		else $error("lock held during wide phase error");
	// The converter forces only from holdover onward.
	chk_dac_force_state: assert property (dac_force |-> loop_state_code >= ST_HOLD)
		else $error("converter forced outside holdover");
	chk_restart_pulse: assert property (div_restart |=> !div_restart)
		else $error("divider restart longer than one cycle");
	// Bus answers come with the stated latency; write responses stay until taken.
	chk_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
		&& axi_rsp.wready |-> ##2 axi_rsp.bvalid)
		else $error("write response late");
	chk_read_answer: assert property (ce && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read response late");
	chk_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
		|=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped before taken");
	chk_busy_refuse: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write accepted while response pending");
	chk_read_refuse: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read accepted while data pending");
endmodule : loop_sup_asserts

bind loop_supervisor loop_sup_asserts u_chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.phase_err_wide(phase_err_wide), .charge_pump_tristate(charge_pump_tristate),
	.dac_force(dac_force), .div_restart(div_restart), .lock_detect(lock_detect),
	.loop_state_code(loop_state_code)
);

`default_nettype wire

// ==== sim/ref_source_model.sv ====
// Reference clock sources and tuned oscillator facing the loop supervisor.
`timescale 1ns/1ns
`default_nettype none

module ref_source_model #(
	parameter int HALF = 20
) (
	input  wire logic [3:0] ref_on,
	input  wire logic       osc_slow,
	output logic [3:0]      ref_clk_in,
	output logic            osc_clk_in
);
	logic rclk;

	// The oscillator runs free; slow mode stretches its period fourfold.
	initial begin
		osc_clk_in = 1'b0;
		forever #(osc_slow ? 4 * HALF : HALF) osc_clk_in = ~osc_clk_in;
	end

	// References share the oscillator rate, so a prescale of one meets the common rate.
	initial begin
		rclk = 1'b0;
		#7;
		forever #HALF rclk = ~rclk;
	end

	// A failed source rests low; switching mid-phase may leave a runt pulse.
	assign ref_clk_in = ref_on & {4{rclk}};
endmodule : ref_source_model

`default_nettype wire

// ==== sim/loop_supervisor_tb.sv ====
// Self-checking bench for the loop supervisor.
`timescale 1ns/1ns
`default_nettype none

module loop_supervisor_tb;
	import loop_sup_pkg::*;
	logic        clk_sys;
	logic        sys_rst;
	axil_req_t   req;
	axil_rsp_t   rsp;
	logic [3:0]  ref_on;
	logic        osc_slow;
	logic [3:0]  ref_clk_in;
	logic        osc_clk_in;
	logic        phase_err_wide;
	logic        phase_slip;
	logic        cp_tri;
	logic        dac_force;
	logic [6:0]  dac_code;
	logic [1:0]  dac_imp;
	logic        div_restart;
	logic        warn;
	logic        lock;
	logic [3:0]  lost;
	logic [2:0]  st;
	logic [31:0] rd;
	logic [1:0]  resp;
	int          bad_count;
	int          checks_done;
	int          cyc;
	int          restarts;

	// Free-running system clock at 125 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	ref_source_model u_src (.ref_on(ref_on), .osc_slow(osc_slow), .ref_clk_in(ref_clk_in),
		.osc_clk_in(osc_clk_in));

	loop_supervisor #(.LOCK_TICKS(8), .IMP_STEPS(4)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .axi_req(req), .axi_rsp(rsp),
		.ref_clk_in(ref_clk_in), .osc_clk_in(osc_clk_in), .phase_err_wide(phase_err_wide),
		.phase_slip(phase_slip), .tuning_sample(7'h55), .charge_pump_tristate(cp_tri),
		.dac_force(dac_force), .dac_code(dac_code), .dac_impedance(dac_imp),
		.div_restart(div_restart), .osc_slow_warn(warn), .lock_detect(lock),
		.signal_lost_flag(lost), .loop_state_code(st)
	);

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	// Counts cycles, divider restart pulses, and cuts a hang short.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (div_restart === 1'b1) begin
			restarts <= restarts + 1;
		end
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One register write; address and data offered together, response awaited.
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
		@(posedge clk_sys);
		req.awaddr <= {idx, 2'b00};
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		resp = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [IDX_W-1:0] idx);
		@(posedge clk_sys);
		req.araddr <= {idx, 2'b00};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rd = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rdr

	// Waits a bounded time for a state code, then compares it.
	task automatic wait_st(input logic [2:0] s, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			if (st === s) break;
		end
		check(st, s);
	endtask : wait_st

	initial begin
		req = '0;
		ref_on = 4'h0;
		osc_slow = 1'b0;
		phase_err_wide = 1'b0;
		phase_slip = 1'b0;
		sys_rst = 1'b1;
		bad_count = 0;
		checks_done = 0;
		cyc = 0;
		restarts = 0;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		check(st, ST_INIT);
		check(lost, 4'hf);
		check(cp_tri, 1'b1);
		check(dac_code, 7'h40);
		check({lock, warn}, 2'b00);
		// Timer select, exit fields, read-only and unmapped places.
		wr(IDX_REVAL, 32'h0000_0007);
		rdr(IDX_REVAL);
		check(rd, 32'h0000_0007);
		rdr(IDX_EXIT);
		check(rd, 32'h0000_0000);
		rdr(10'h3ff);
		check(resp, RESP_SLVERR);
		// No reference is usable yet, so the machine waits in preload.
		wr(IDX_STATE, 32'h0000_0007);
		rdr(IDX_STATE);
		check(rd, 32'(ST_PRELOAD));
		wr(IDX_REVAL, 32'h0000_0001);
		check(resp, RESP_OKAY);
		wr(IDX_HOLD, 32'h0000_0004);
		wr(IDX_EXIT, 32'h0000_000C);
		rdr(IDX_EXIT);
		check(rd, 32'h0000_000C);
		// Acquire lock on good references.
		ref_on <= 4'hf;
		wait_st(ST_LOCKED, 2000);
		check({lost, lock, cp_tri}, 6'b000010);
		rdr(IDX_STATE);
		check(rd, 32'h0000_0003);
		// Lose every reference: holdover with the converter forcing.
		ref_on <= 4'h0;
		wait_st(ST_HOLD, 300);
		check(lost, 4'hf);
		check({cp_tri, dac_force}, 2'b11);
		ref_on <= 4'hf;
		repeat (12) @(posedge clk_sys);
		check(lost[0], 1'b1);
		wait_st(ST_EXIT_RAMP, 300);
		// One more edge lets the restart counter take the pulse in.
		@(posedge clk_sys);
		check(restarts, 1);
		check({dac_force, dac_imp}, 3'b100);
		wait_st(ST_LOCKED, 600);
		// Wide phase error, then exit on the cycle slip.
		wr(IDX_EXIT, 32'h0000_0005);
		phase_err_wide <= 1'b1;
		repeat (6) @(posedge clk_sys);
		check({cp_tri, lock}, 2'b10);
		phase_err_wide <= 1'b0;
		wait_st(ST_EXIT_SLIP, 300);
		repeat (20) @(posedge clk_sys);
		check({st, cp_tri}, {ST_EXIT_SLIP, 1'b1});
		phase_slip <= 1'b1;
		repeat (8) @(posedge clk_sys);
		phase_slip <= 1'b0;
		wait_st(ST_LOCKED, 600);
		check(restarts, 1);
		// Slow oscillator warns but the loop stays put.
		osc_slow <= 1'b1;
		repeat (200) @(posedge clk_sys);
		check({warn, st}, {1'b1, ST_LOCKED});
		osc_slow <= 1'b0;
		// Manual mode flags a lost reference but takes no action.
		wr(IDX_CTRL, 32'h0000_00F0);
		ref_on <= 4'he;
		repeat (100) @(posedge clk_sys);
		check({lost[0], st}, {1'b1, ST_LOCKED});
		// Tristate-only holdover forced by hand, left through the divider reset.
		wr(IDX_HOLD, 32'h0000_0000);
		wr(IDX_EXIT, 32'h0000_0000);
		wr(IDX_CTRL, 32'h0000_00F2);
		wait_st(ST_HOLD, 300);
		check({cp_tri, dac_force}, 2'b10);
		check(32'(dac_code > 7'h40 && dac_code <= 7'h55), 32'h0000_0001);
		wr(IDX_CTRL, 32'h0000_00F0);
		wait_st(ST_LOCKED, 300);
		check(restarts, 2);
		summarize();
	end
endmodule : loop_supervisor_tb

`default_nettype wire
